// ### logic/lfw_consts.svh
/*
  constants of the lf receiver control block.
  assumes a 100 MHz hclk and a 1 ms low-frequency timebase tick.
*/
// Summary of operation
// R1: carrier ack one clears carrier flag
// R2: code b match sets bit 3
// R3: code a match sets bit 2
// R4: validity zero while detector off
// R5: validity set on coding violation (code sets it only while a code a or b match flag is set)
// R6: ignore bit holds detector low
// R7: mode 0:1 selects carrier mode
// R8: carrier time 88 or 176 us
// R9: sample time 200 or 2120 us
// R10: rate field sets sample interval
// R11: carrier detect raises interrupt
// R12: lockout one or two periods
// R13: detector powered only when enabled
// R14: software configures before enable
// R15: level one is lower sensitivity
// R16: software monitors carrier flag
// R17: wake codes are plain storage
// R18: received data is read only
// R19: software acks data flags at init
// R20: carrier flag after minimum time
// R21: data ack clears data, validity, matches
// R22: flags sticky, irq while enabled
`ifndef LFW_CONSTS_SVH
`define LFW_CONSTS_SVH
// register byte offsets
`define LFW_OFS_MODE    8'h00
`define LFW_OFS_CS0     8'h04
`define LFW_OFS_CS1     8'h08
`define LFW_OFS_CODE_A0 8'h0C
`define LFW_OFS_CODE_A1 8'h10
`define LFW_OFS_CODE_B0 8'h14
`define LFW_OFS_CODE_B1 8'h18
`define LFW_OFS_RXDATA  8'h1C
// mode register fields
`define LFW_MODE_HI   7
`define LFW_MODE_LO   6
`define LFW_CT_BIT    5
`define LFW_ON_BIT    4
`define LFW_RATE_HI   3
// control/status 0 fields
`define LFW_DO_BIT    7
`define LFW_IE_BIT    6
`define LFW_OFF_BIT   5
`define LFW_RST_BIT   4
`define LFW_EN_BIT    3
`define LFW_WU8_BIT   2
`define LFW_LVL_BIT   1
`define LFW_AGC_BIT   0
// control/status 1 fields
`define LFW_DF_BIT    7
`define LFW_DFAK_BIT  6
`define LFW_CF_BIT    5
`define LFW_CFAK_BIT  4
`define LFW_BF_BIT    3
`define LFW_AF_BIT    2
`define LFW_MD_BIT    1
`define LFW_IG_BIT    0
// reset values
`define LFW_RST_MODE  8'h00
`define LFW_RST_CS0   8'h00
// timing
`define LFW_CLK_MHZ       100
`define LFW_TICK_US       1000
`define LFW_CD_SHORT_US   88
`define LFW_CD_LONG_US    176
`define LFW_ON_SHORT_US   200
`define LFW_ON_LONG_US    2120
`define LFW_TICK_CYC      (`LFW_TICK_US * `LFW_CLK_MHZ)
`define LFW_CD_SHORT_CYC  (`LFW_CD_SHORT_US * `LFW_CLK_MHZ)
`define LFW_CD_LONG_CYC   (`LFW_CD_LONG_US * `LFW_CLK_MHZ)
`define LFW_ON_SHORT_CYC  (`LFW_ON_SHORT_US * `LFW_CLK_MHZ)
`define LFW_ON_LONG_CYC   (`LFW_ON_LONG_US * `LFW_CLK_MHZ)
`endif

// ### logic/lfw_pkg.sv
/*
  types of the lf receiver control block.
  assumes nothing beyond a SystemVerilog compiler.
*/
package lfw_pkg;
  // receiver mode field encoding
  typedef enum logic [1:0] {
    LFW_MODE_DIRECT  = 2'h0,
    LFW_MODE_CARRIER = 2'h1,
    LFW_MODE_MANCH   = 2'h2,
    LFW_MODE_RSVD    = 2'h3
  } lfw_mode_e;
  // sample scheduler states, one-hot
  typedef enum logic [2:0] {
    LFW_ST_IDLE   = 3'b001,
    LFW_ST_SAMPLE = 3'b010,
    LFW_ST_WAIT   = 3'b100
  } lfw_state_e;
endpackage

// ### logic/lfw_ctrl_if.sv
/*
  interface between the register block and its scheduler and carrier qualifier.
  assumes all three run on hclk.
*/
`timescale 1ns/100ps
interface lfw_ctrl_if;
  logic       detector_enable;     // module on
  logic       carrier_mode;        // carrier mode
  logic       carrier_time_select; // long carrier
  logic       sample_time_select;  // long sample
  logic [3:0] sample_rate_field;   // log2 interval
  logic       lockout_length;      // double lockout
  logic       ignore_detector;     // decoder sees low
  logic       sample_active;       // sampling
  logic       sample_start;        // sample start pulse
  logic       det_sync;            // synced level
  logic       det_masked;          // decoder view
  logic       carrier_hit;         // carrier pulse
  modport regs  (output detector_enable, carrier_mode, carrier_time_select, sample_time_select,
                 sample_rate_field, lockout_length, ignore_detector,
                 input sample_active, sample_start, det_sync, det_masked, carrier_hit);
  modport sched (input detector_enable, sample_time_select, sample_rate_field, lockout_length,
                 output sample_active, sample_start);
  modport qual  (input detector_enable, carrier_mode, carrier_time_select, ignore_detector,
                 sample_active, output det_sync, det_masked, carrier_hit);
endinterface // lfw_ctrl_if

// ### logic/lfw_sample_sched.sv
/*
  sample scheduler: opens a sample time once per sample interval.
  assumes hclk at 100 MHz and configuration written before enable.
*/
`timescale 1ns/100ps
`include "lfw_consts.svh"
module lfw_sample_sched #(
  parameter int TICK_CYC     = `LFW_TICK_CYC,
  parameter int ON_SHORT_CYC = `LFW_ON_SHORT_CYC,
  parameter int ON_LONG_CYC  = `LFW_ON_LONG_CYC
) (
  input wire logic  hclk,
  input wire logic  hresetn,
  lfw_ctrl_if.sched cif
);
  import lfw_pkg::*;
  if (TICK_CYC < 1 || ON_SHORT_CYC < 1 || ON_LONG_CYC < ON_SHORT_CYC) begin : g_chk
    $error("lfw_sample_sched: bad timing parameters");
  end

  lfw_state_e  state_ff;    // scheduler state
  logic [31:0] tick_cnt_ff; // cycles within a timebase tick
  logic [31:0] win_cnt_ff;  // cycles within sample time
  logic [31:0] per_cnt_ff;  // ticks within interval
  logic        tick;        // one timebase tick
  logic [31:0] win_len;     // sample time in cycles
  logic [31:0] per_len;     // interval in ticks

  assign tick = (tick_cnt_ff == 32'(TICK_CYC - 1));
  // R9: sample time length
  assign win_len = cif.sample_time_select ? 32'(ON_LONG_CYC) : 32'(ON_SHORT_CYC);
  // R10 R12: interval in ticks
  assign per_len = (32'h1 << cif.sample_rate_field) << cif.lockout_length;

  ////////////////////////////////////////////////////////////////
  // timebase tick counter, phased to the first sample start
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick_cnt_ff <= 32'h0;
    end else if (tick || !cif.detector_enable || state_ff == LFW_ST_IDLE) begin
      tick_cnt_ff <= 32'h0;
    end else begin
      tick_cnt_ff <= tick_cnt_ff + 32'h1;
    end
  end

  ////////////////////////////////////////////////////////////////
  // sample, then wait out the interval
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_ff   <= LFW_ST_IDLE;
      win_cnt_ff <= 32'h0;
      per_cnt_ff <= 32'h0;
    end else if (!cif.detector_enable) begin
      // R13: no sampling while disabled
      state_ff <= LFW_ST_IDLE;
    end else begin
      case (state_ff)
        LFW_ST_IDLE: begin
          state_ff   <= LFW_ST_SAMPLE;
          win_cnt_ff <= 32'h0;
          per_cnt_ff <= 32'h0;
        end
        LFW_ST_SAMPLE: begin
          win_cnt_ff <= win_cnt_ff + 32'h1;
          if (tick) begin
            per_cnt_ff <= per_cnt_ff + 32'h1;
          end
          if (win_cnt_ff >= win_len - 32'h1) begin
            state_ff <= LFW_ST_WAIT;
          end
        end
        LFW_ST_WAIT: begin
          if (tick) begin
            if (per_cnt_ff >= per_len - 32'h1) begin
              state_ff   <= LFW_ST_SAMPLE;
              win_cnt_ff <= 32'h0;
              per_cnt_ff <= 32'h0;
            end else begin
              per_cnt_ff <= per_cnt_ff + 32'h1;
            end
          end
        end
        default: begin
          state_ff <= LFW_ST_IDLE;
        end
      endcase
    end
  end

  assign cif.sample_active = (state_ff == LFW_ST_SAMPLE);
  assign cif.sample_start  = (state_ff == LFW_ST_SAMPLE) && (win_cnt_ff == 32'h0);
endmodule // lfw_sample_sched

// ### logic/lfw_carrier_qual.sv
/*
  carrier qualifier: syncs the pin, times carrier.
  assumes the detector level is asynchronous to hclk.
*/
`timescale 1ns/100ps
`include "lfw_consts.svh"
module lfw_carrier_qual #(
  parameter int CD_SHORT_CYC = `LFW_CD_SHORT_CYC,
  parameter int CD_LONG_CYC  = `LFW_CD_LONG_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic det_pin,
  lfw_ctrl_if.qual cif
);
  import lfw_pkg::*;
  if (CD_SHORT_CYC < 1 || CD_LONG_CYC < CD_SHORT_CYC) begin : g_chk
    $error("lfw_carrier_qual: bad carrier time parameters");
  end

  logic        sync1_ff; // first synchroniser stage
  logic        sync2_ff; // second synchroniser stage
  logic [31:0] run_ff;   // cycles of continuous carrier
  logic        done_ff;  // carrier already reported this sample
  logic [31:0] min_len;  // minimum carrier in cycles

  ////////////////////////////////////////////////////////////////
  // two-stage synchroniser
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
    end else begin
      sync1_ff <= det_pin;
      sync2_ff <= sync1_ff;
    end
  end

  assign cif.det_sync = sync2_ff;
  // R6: ignore bit forces the decoder view low
  assign cif.det_masked = sync2_ff && !cif.ignore_detector && cif.sample_active;
  // R8: minimum carrier length
  assign min_len = cif.carrier_time_select ? 32'(CD_LONG_CYC) : 32'(CD_SHORT_CYC);

  ////////////////////////////////////////////////////////////////
  // carrier run-length timer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      run_ff  <= 32'h0;
      done_ff <= 1'b0;
    end else if (!cif.det_masked || !cif.carrier_mode) begin
      run_ff  <= 32'h0;
      done_ff <= !cif.sample_active ? 1'b0 : done_ff;
    end else if (!done_ff) begin
      run_ff  <= run_ff + 32'h1;
      done_ff <= (run_ff >= min_len - 32'h1);
    end
  end

  // R20: pulse past minimum carrier
  assign cif.carrier_hit = cif.det_masked && cif.carrier_mode && !done_ff &&
                           (run_ff >= min_len - 32'h1);
endmodule // lfw_carrier_qual

// ### logic/lfw_receiver.sv
/*
  lf wake-up receiver control and status registers with an AHB-Lite slave.
  assumes a single-master AHB-Lite bus on hclk, word transfers only,
  and decoder events that are single-cycle pulses on hclk.
*/
// Added by the designer: register access over AHB-Lite and the register addresses.
`timescale 1ns/100ps
`include "lfw_consts.svh"
module lfw_receiver #(
  parameter int TICK_CYC     = `LFW_TICK_CYC,
  parameter int ON_SHORT_CYC = `LFW_ON_SHORT_CYC,
  parameter int ON_LONG_CYC  = `LFW_ON_LONG_CYC,
  parameter int CD_SHORT_CYC = `LFW_CD_SHORT_CYC,
  parameter int CD_LONG_CYC  = `LFW_CD_LONG_CYC
) (
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic [31:0]            hrdata,
  output logic                   hreadyout,
  output logic                   hresp,
  input  wire logic              det_pin,
  input  wire logic              code_a_hit,
  input  wire logic              code_b_hit,
  input  wire logic              data_accept,
  input  wire logic [7:0]        rx_byte,
  input  wire logic              code_violation,
  output logic                   det_power_en,
  output logic                   decoder_in,
  output logic                   detector_level,
  output lfw_pkg::lfw_mode_e     receiver_mode,
  output logic                   irq
);
  import lfw_pkg::*;

  lfw_ctrl_if cif ();

  lfw_sample_sched #(
    .TICK_CYC     (TICK_CYC),
    .ON_SHORT_CYC (ON_SHORT_CYC),
    .ON_LONG_CYC  (ON_LONG_CYC)
  ) u_sched (
    .hclk    (hclk),
    .hresetn (hresetn),
    .cif     (cif.sched)
  );

  lfw_carrier_qual #(
    .CD_SHORT_CYC (CD_SHORT_CYC),
    .CD_LONG_CYC  (CD_LONG_CYC)
  ) u_qual (
    .hclk    (hclk),
    .hresetn (hresetn),
    .det_pin (det_pin),
    .cif     (cif.qual)
  );

  ////////////////////////////////////////////////////////////////
  // register state
  logic [7:0]  mode_ff;        // mode control
  logic [7:0]  cs0_ff;         // control/status 0
  logic        ignore_ff;      // ignore bit

  logic        carrier_ff;     // carrier flag
  logic        data_ready_ff;  // data ready flag
  logic        code_a_ff;      // code a match flag
  logic        code_b_ff;      // code b match flag

  logic        validity_ff;    // manchester validity
  logic        lockout_ff;     // lockout status

  logic [7:0]  rxdata_ff;      // received data
  logic [7:0]  code_mem [4];   // wake codes

  logic [7:0]  agc_level;      // gain readback stand-in

  // bus pipeline
  logic        wr_pend_ff;     // write pending
  logic        rd_pend_ff;     // read pending
  logic [7:0]  addr_ff;        // offset
  logic [31:0] hrdata_ff;      // read data

  logic        hreadyout_ff;   // ready
  logic        irq_ff;         // irq

  logic        power_ff;       // power
  logic        dec_ff;         // decoder view

  logic        addr_ok;        // address taken
  logic        wr_now;         // write commit

  logic [7:0]  wb;             // write byte

  assign addr_ok   = hsel && hready && htrans[1];
  assign wr_now    = wr_pend_ff;
  assign wb        = hwdata[7:0];
  assign agc_level = 8'h00;

  // checks whether an offset names a wake code register
  function automatic logic is_code(input logic [7:0] a);
    is_code = (a == `LFW_OFS_CODE_A0) || (a == `LFW_OFS_CODE_A1) ||
              (a == `LFW_OFS_CODE_B0) || (a == `LFW_OFS_CODE_B1);
  endfunction

  // index into the wake code storage
  function automatic logic [1:0] code_idx(input logic [7:0] a);
    code_idx = 2'(((a - `LFW_OFS_CODE_A0) >> 2));
  endfunction

  ////////////////////////////////////////////////////////////////
  // address phase capture
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_ff <= 1'b0;
      rd_pend_ff <= 1'b0;
      addr_ff    <= 8'h00;
    end else begin
      wr_pend_ff <= addr_ok && hwrite;
      rd_pend_ff <= addr_ok && !hwrite;
      if (addr_ok) begin
        addr_ff <= haddr[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // ready: one wait cycle for reads, none for writes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout_ff <= 1'b1;
    end else begin
      hreadyout_ff <= !(addr_ok && !hwrite);
    end
  end

  ////////////////////////////////////////////////////////////////
  // mode and control registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_ff   <= `LFW_RST_MODE;
      cs0_ff    <= `LFW_RST_CS0;
      ignore_ff <= 1'b0;
    end else if (wr_now) begin
      // R7: mode field and R15: level are plain control bits
      if (addr_ff == `LFW_OFS_MODE) begin
        mode_ff <= wb;
      end
      if (addr_ff == `LFW_OFS_CS0) begin
        cs0_ff <= wb;
      end
      if (addr_ff == `LFW_OFS_CS1) begin
        ignore_ff <= wb[`LFW_IG_BIT];
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // wake code storage, plain memory in every mode
  always_ff @(posedge hclk) begin
    // R17: read and write as general storage
    if (wr_now && is_code(addr_ff)) begin
      code_mem[code_idx(addr_ff)] <= wb;
    end
  end

  ////////////////////////////////////////////////////////////////
  // received data, loaded only by the decoder
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rxdata_ff <= 8'h00;
    end else if (data_accept) begin
      // R18: bus writes never reach this register
      rxdata_ff <= rx_byte;
    end
  end

  logic ack_cf; // carrier ack written
  logic ack_df; // data ack written
  assign ack_cf = wr_now && (addr_ff == `LFW_OFS_CS1) && wb[`LFW_CFAK_BIT];
  assign ack_df = wr_now && (addr_ff == `LFW_OFS_CS1) && wb[`LFW_DFAK_BIT];

  ////////////////////////////////////////////////////////////////
  // carrier flag, set wins over ack
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      carrier_ff <= 1'b0;
    end else if (cif.carrier_hit && cif.detector_enable) begin
      // R20: qualified carrier sets the flag
      carrier_ff <= 1'b1;
    end else if (ack_cf) begin
      // R1: write one clears, zero leaves it; R22: sticky until then
      carrier_ff <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////
  // data and match flags, set wins over ack
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      data_ready_ff <= 1'b0;
      code_a_ff     <= 1'b0;
      code_b_ff     <= 1'b0;
    end else begin
      // R21: data ack clears data and match flags
      data_ready_ff <= data_accept || (data_ready_ff && !ack_df);
      // R3: code a match
      code_a_ff     <= code_a_hit || (code_a_ff && !ack_df);
      // R2: code b match
      code_b_ff     <= code_b_hit || (code_b_ff && !ack_df);
    end
  end

  ////////////////////////////////////////////////////////////////
  // manchester validity and lockout status
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      validity_ff <= 1'b0;
      lockout_ff  <= 1'b0;
    end else if (!cif.detector_enable) begin
      // R4: forced low while the detector is off
      validity_ff <= 1'b0;
      lockout_ff  <= 1'b0;
    end else begin
      // R5: violation after a match ends the frame; R21: ack clears
      validity_ff <= (code_violation && (code_a_ff || code_b_ff)) ||
                     (validity_ff && !ack_df);
      // lockout runs from violation to next sample start
      lockout_ff  <= code_violation || (lockout_ff && !cif.sample_start);
    end
  end

  ////////////////////////////////////////////////////////////////
  // read data, taken in the wait cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_ff <= 32'h0;
    end else if (rd_pend_ff) begin
      case (addr_ff)
        `LFW_OFS_MODE: begin
          hrdata_ff <= {24'h0, mode_ff};
        end
        `LFW_OFS_CS0: begin
          hrdata_ff <= {24'h0, cif.det_sync, cs0_ff[`LFW_IE_BIT], lockout_ff, cs0_ff[4:0]};
        end
        `LFW_OFS_CS1: begin
          hrdata_ff <= {24'h0, data_ready_ff, 1'b0, carrier_ff, 1'b0,
                        code_b_ff, code_a_ff, validity_ff, ignore_ff};
        end
        `LFW_OFS_CODE_A0, `LFW_OFS_CODE_A1, `LFW_OFS_CODE_B0, `LFW_OFS_CODE_B1: begin
          hrdata_ff <= {24'h0, code_mem[code_idx(addr_ff)]};
        end
        `LFW_OFS_RXDATA: begin
          hrdata_ff <= {24'h0, cs0_ff[`LFW_AGC_BIT] ? rxdata_ff : agc_level};
        end
        default: begin
          hrdata_ff <= 32'h0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////
  // configuration to scheduler and qualifier
  assign cif.detector_enable     = cs0_ff[`LFW_EN_BIT];
  // R7: carrier mode when the mode field is 0:1
  assign cif.carrier_mode        = (mode_ff[`LFW_MODE_HI:`LFW_MODE_LO] == LFW_MODE_CARRIER);
  assign cif.carrier_time_select = mode_ff[`LFW_CT_BIT];
  assign cif.sample_time_select  = mode_ff[`LFW_ON_BIT];
  assign cif.sample_rate_field   = mode_ff[`LFW_RATE_HI:0];
  assign cif.lockout_length      = cs0_ff[`LFW_RST_BIT];
  assign cif.ignore_detector     = ignore_ff;

  ////////////////////////////////////////////////////////////////
  // registered pin outputs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      power_ff <= 1'b0;
      dec_ff   <= 1'b0;
      irq_ff   <= 1'b0;
    end else begin
      // R13: powered only when enabled and sampling
      power_ff <= cif.detector_enable && cif.sample_active;
      // R6: decoder sees the masked level
      dec_ff   <= cif.det_masked;
      // R11: carrier interrupt; R22: carrier, data or match flag holds it while enabled
      irq_ff   <= cs0_ff[`LFW_IE_BIT] &&
                  (carrier_ff || data_ready_ff || code_a_ff || code_b_ff);
    end
  end

  assign hrdata         = hrdata_ff;
  assign hreadyout      = hreadyout_ff;
  assign hresp          = 1'b0;
  assign det_power_en   = power_ff;
  assign decoder_in     = dec_ff;
  // R15: one selects lower sensitivity
  assign detector_level = cs0_ff[`LFW_LVL_BIT];
  assign receiver_mode  = lfw_mode_e'(mode_ff[`LFW_MODE_HI:`LFW_MODE_LO]);
  assign irq            = irq_ff;
endmodule // lfw_receiver

// ### testbench/lfw_receiver_assertions.sv
/* checker of the lf receiver top ports.
   assumes hready equals hreadyout (single slave). */
`timescale 1ns/100ps
`include "lfw_consts.svh"
module lfw_receiver_assertions (
  input wire logic           hclk,
  input wire logic           hresetn,
  input wire logic           hsel,
  input wire logic [31:0]    haddr,
  input wire logic [1:0]     htrans,
  input wire logic           hwrite,
  input wire logic [31:0]    hwdata,
  input wire logic           hready,
  input wire logic           hreadyout,
  input wire logic           hresp,
  input wire logic           code_a_hit,
  input wire logic           code_b_hit,
  input wire logic           det_power_en,
  input wire logic           decoder_in,
  input wire logic           detector_level,
  input lfw_pkg::lfw_mode_e  receiver_mode,
  input wire logic           irq
);
  import lfw_pkg::*;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic       wp_ff;   // write data phase pending
  logic [7:0] wa_ff;   // its offset
  logic       ie_ff;   // shadow irq enable
  logic       lvl_ff;  // shadow level bit
  logic [1:0] md_ff;   // shadow mode field
  // track write address phases
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wp_ff <= 1'h0;
      wa_ff <= 8'h00;
    end else if (hready) begin
      wp_ff <= hsel & htrans[1] & hwrite;
      wa_ff <= haddr[7:0];
    end
  end
  // shadow control bits at commit
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {ie_ff, lvl_ff, md_ff} <= 4'h0;
    end else if (wp_ff && hready) begin
      if (wa_ff == `LFW_OFS_CS0) {ie_ff, lvl_ff} <= {hwdata[`LFW_IE_BIT], hwdata[`LFW_LVL_BIT]};
      if (wa_ff == `LFW_OFS_MODE) md_ff <= hwdata[7:6];
    end
  end
  a_read_wait: assert property (hsel && hready && htrans[1] && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  a_write_nowait: assert property (hsel && hready && htrans[1] && hwrite |=> hreadyout)
    else $error("write stalled");
  a_resp_okay: assert property (hresp == 1'h0) else $error("error response");
  a_dec_gated: assert property (decoder_in |-> det_power_en || $past(det_power_en) || $past(det_power_en, 2))
    else $error("decoder on while off");
  a_level_copy: assert property (detector_level == lvl_ff) else $error("level output wrong");
  a_mode_copy: assert property (receiver_mode == md_ff) else $error("mode output wrong");
  a_hit_irq: assert property ((code_a_hit || code_b_hit) && ie_ff ##1 ie_ff |=> irq)
    else $error("code match raised no irq");
  a_irq_gate: assert property (irq |-> $past(ie_ff)) else $error("irq while disabled");
  cover property (hsel && htrans[1] && !hwrite);
  cover property ($rose(det_power_en));
  cover property ($rose(irq));
endmodule // lfw_receiver_assertions
bind lfw_receiver lfw_receiver_assertions i_lfw_receiver_assertions (.*);

// ### testbench/lfw_tx_model.sv
/* burst source seen through the detector.
   assumes det_power_en marks listening. */
`timescale 1ns/100ps
module lfw_tx_model (
  input wire logic       hclk,
  input wire logic       det_power_en,
  input wire logic [7:0] burst_len,
  output logic           det_pin
);
  logic       pw_ff  = 1'h0;  // last power state
  logic [7:0] cnt_ff = 8'h00; // burst cycles left
  // start a burst at each power-up, energy lasts burst_len cycles
  always_ff @(posedge hclk) begin
    pw_ff <= det_power_en;
    if (det_power_en && !pw_ff) cnt_ff <= burst_len;
    else if (cnt_ff != 8'h00) cnt_ff <= cnt_ff - 8'h01;
  end
  assign det_pin = (cnt_ff != 8'h00); // no carrier reads low
endmodule // lfw_tx_model

// ### testbench/lfw_receiver_tb.sv
/* self-checking bench of the lf receiver registers.
   assumes shortened timing parameters. */
`timescale 1ns/100ps
`include "lfw_consts.svh"
module lfw_receiver_tb;
  import lfw_pkg::*;
  logic hclk = 1'h0, hresetn = 1'h0, hsel = 1'h0, hwrite = 1'h0, hreadyout, hresp, det_pin, pe, dec, lvl, irq;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, seed = 32'hBAE7;
  logic [3:0] ev = 4'h0; // accept, violation, code b, code a
  logic [7:0] rxb = 8'h00, blen = 8'h00, q, w, p, r[4];
  logic ct, st, rs, ig, ex;
  lfw_mode_e md;
  int error_cnt = 0, check_count = 0, cyc = 0;
  logic [4:0] row[5] = '{5'h05, 5'h00, 5'h1C, 5'h11, 5'h06}; // ct st rst ig expect
  logic [7:0] len[5] = '{8'h0F, 8'h03, 8'h08, 8'h0F, 8'h0F};
  lfw_receiver #(.TICK_CYC(10), .ON_SHORT_CYC(20), .ON_LONG_CYC(40), .CD_SHORT_CYC(5), .CD_LONG_CYC(10))
    i_lfw_receiver (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
    .hrdata, .hreadyout, .hresp, .det_pin, .code_a_hit(ev[0]), .code_b_hit(ev[1]), .data_accept(ev[3]),
    .rx_byte(rxb), .code_violation(ev[2]), .det_power_en(pe), .decoder_in(dec), .detector_level(lvl),
    .receiver_mode(md), .irq);
  lfw_tx_model i_lfw_tx_model (.hclk, .det_power_en(pe), .burst_len(blen), .det_pin);
  always #5 hclk = ~hclk;
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h expected=%h", $time, g, e);
    end
  endtask
  // one AHB single word transfer, waits on hready
  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d, output logic [7:0] rd);
    @(posedge hclk);
    {hsel, htrans, hwrite, hsize, haddr} <= {1'h1, 2'h2, wr, 3'h2, 24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'h1);
    {hsel, htrans, hwdata} <= {1'h0, 2'h0, 24'h0, d};
    do @(posedge hclk); while (hreadyout !== 1'h1);
    rd = hrdata[7:0];
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    bus(0, a, 8'h00, q);
    chk(q, e);
  endtask
  task automatic pulse(input logic [3:0] m);
    @(posedge hclk) ev <= m;
    @(posedge hclk) ev <= 4'h0;
  endtask
  task automatic end_sim;
    $display("errors %0d checks %0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // hang guard
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      end_sim();
    end
  end
  initial begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'h1;
    rc(`LFW_OFS_MODE, `LFW_RST_MODE);
    rc(`LFW_OFS_CS0, `LFW_RST_CS0);
    rc(8'h20, 8'h00);
    // init data ack
    bus(1, `LFW_OFS_CS1, 8'h40, q);
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      r[i] = seed[7:0];
      bus(1, `LFW_OFS_CODE_A0 + 8'(4 * i), r[i], q);
    end
    for (int i = 0; i < 4; i++) rc(`LFW_OFS_CODE_A0 + 8'(4 * i), r[i]);
    seed = xs(seed);
    rxb <= seed[7:0];
    bus(1, `LFW_OFS_CS0, 8'h49, q);
    pulse(4'h1); rc(`LFW_OFS_CS1, 8'h04);
    chk(8'(irq), 8'h01);
    pulse(4'h2); rc(`LFW_OFS_CS1, 8'h0C);
    pulse(4'h8); pulse(4'h4); rc(`LFW_OFS_CS1, 8'h8E);
    bus(1, `LFW_OFS_RXDATA, ~rxb, q); rc(`LFW_OFS_RXDATA, rxb);
    bus(1, `LFW_OFS_CS1, 8'h40, q); rc(`LFW_OFS_CS1, 8'h00);
    chk(8'(irq), 8'h00);
    pulse(4'h1); pulse(4'h4); bus(1, `LFW_OFS_CS0, 8'h40, q);
    rc(`LFW_OFS_CS1, 8'h04);
    bus(1, `LFW_OFS_CS1, 8'h40, q);
    for (int k = 0; k < 5; k++) begin
      {ct, st, rs, ig, ex} = row[k];
      blen <= len[k];
      // configure before enable
      bus(1, `LFW_OFS_CS1, {7'h0, ig}, q);
      bus(1, `LFW_OFS_MODE, {2'h1, ct, st, 4'h2}, q);
      rc(`LFW_OFS_MODE, {2'h1, ct, st, 4'h2});
      bus(1, `LFW_OFS_CS0, {3'h2, rs, 4'hA}, q);
      w = 8'h00;
      while (pe !== 1'h1 && w != 8'hFF) begin @(posedge hclk); w++; end
      w = 8'h00;
      while (pe === 1'h1 && w != 8'hFF) begin @(posedge hclk); w++; end
      chk(w, st ? 8'h28 : 8'h14);
      p = w;
      while (pe !== 1'h1 && p != 8'hFF) begin @(posedge hclk); p++; end
      chk(p, 8'h28 << rs);
      repeat (48) @(posedge hclk);
      // software watches the carrier flag
      chk(8'(irq), 8'(ex));
      bus(1, `LFW_OFS_CS0, 8'h00, q);
      rc(`LFW_OFS_CS1, {2'h0, ex, 4'h0, ig});
      bus(1, `LFW_OFS_CS1, {7'h0, ig}, q);
      rc(`LFW_OFS_CS1, {2'h0, ex, 4'h0, ig});
      bus(1, `LFW_OFS_CS1, 8'h10, q);
      rc(`LFW_OFS_CS1, 8'h00);
    end
    end_sim();
  end
endmodule // lfw_receiver_tb
